// *** design/uptr_params.svh ***
/*
 * Offsets, field positions and reset values of the port tuning bank.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef UPTR_PARAMS_SVH
`define UPTR_PARAMS_SVH

// ==========================================================
// Register offsets
`define UPTR_ADDR_W 16
`define UPTR_OFF_P2_LINK 16'h69C0
`define UPTR_OFF_P3_DRIVE 16'h6CCA
`define UPTR_OFF_P3_SQUELCH 16'h6CCC
`define UPTR_OFF_P3_LINK 16'h6DC0
`define UPTR_OFF_P4_DRIVE 16'h70CA
`define UPTR_OFF_P4_SQUELCH 16'h70CC
`define UPTR_OFF_P4_LINK 16'h71C0

// ==========================================================
// Field layout
`define UPTR_STATE_HI 7
`define UPTR_STATE_LO 4
`define UPTR_RSVD_BIT 3
`define UPTR_SUB_HI 2
`define UPTR_SUB_LO 0
`define UPTR_TRIM_HI 2
`define UPTR_TRIM_LO 0
`define UPTR_UPPER_HI 7
`define UPTR_UPPER_LO 3

// ==========================================================
// Reset values
`define UPTR_TRIM_NOMINAL 3'h0
`define UPTR_UPPER_RESET 5'h00
`define UPTR_BYTE_ZERO 8'h00
`define UPTR_RSVD_ZERO 1'h0
`define UPTR_SYNC_RESET 14'h0000
`define UPTR_LINK_RESET 7'h00

`endif

// *** design/uptr_pkg.sv ***
/*
 * Types shared by the port tuning bank.
 * Assumes uptr_params.svh is on the include path.
 */
`include "uptr_params.svh"

package uptr_pkg;

    // ======================================================
    // Link status as seen from the link layer
    typedef struct packed {
        logic [3:0] state;
        logic [2:0] sub_state;
    } uptr_link_t;

    // ======================================================
    // Trim settings driven to the analog front end
    typedef struct packed {
        logic [2:0] drive;
        logic [2:0] squelch;
    } uptr_trim_t;

    // ======================================================
    // Register select decoded from the bus address
    typedef enum {
        UPTR_SEL_NONE,
        UPTR_SEL_P2_LINK,
        UPTR_SEL_P3_DRIVE,
        UPTR_SEL_P3_SQUELCH,
        UPTR_SEL_P3_LINK,
        UPTR_SEL_P4_DRIVE,
        UPTR_SEL_P4_SQUELCH,
        UPTR_SEL_P4_LINK
    } uptr_sel_t;

endpackage

// *** design/uptr_port_tuning_regs.sv ***
/*
 * Byte-wide register bank: link status of ports 2 to 4 and high-speed
 * drive and squelch trims of ports 3 and 4.
 * Assumes a single-cycle strobe bus master on CLK and link status
 * inputs from another clock domain, which are synchronised here.
 */
// Added by the designer: the strobed register port.
//
// Contract
// - Port 2 link status at 0x69C0, state in bits 7:4, read-only.
// - Port 3 link status at 0x6DC0, sub-state in bits 2:0, read-only.
// - Port 4 link status at 0x71C0, same layout, bit 3 reserved zero.
// - Port 3 drive trim at 0x6CCA, bits 7:0 writable, trim in 2:0, 000 nominal.
// - Port 4 drive trim at 0x70CA, upper bits 7:3 also writable.
// - Port 3 squelch trim at 0x6CCC, bits 2:0 writable, 7:3 read zero.
// - Port 4 squelch trim at 0x70CC, same layout as port 3.
// - Squelch code 000 is the nominal 100 mV trip point.
`timescale 1ns/1ps
`include "uptr_params.svh"

module uptr_port_tuning_regs
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire uptr_pkg::uptr_link_t P2_LINK,
    input wire uptr_pkg::uptr_link_t P3_LINK,
    input wire uptr_pkg::uptr_link_t P4_LINK,
    output uptr_pkg::uptr_trim_t P3_TRIM,
    output uptr_pkg::uptr_trim_t P4_TRIM
);

    // ======================================================
    // Address decode
    function automatic uptr_pkg::uptr_sel_t decode
    (
        input logic [15:0] a
    );
        case (a)
            `UPTR_OFF_P2_LINK: decode = uptr_pkg::UPTR_SEL_P2_LINK;
            `UPTR_OFF_P3_DRIVE: decode = uptr_pkg::UPTR_SEL_P3_DRIVE;
            `UPTR_OFF_P3_SQUELCH: decode = uptr_pkg::UPTR_SEL_P3_SQUELCH;
            `UPTR_OFF_P3_LINK: decode = uptr_pkg::UPTR_SEL_P3_LINK;
            `UPTR_OFF_P4_DRIVE: decode = uptr_pkg::UPTR_SEL_P4_DRIVE;
            `UPTR_OFF_P4_SQUELCH: decode = uptr_pkg::UPTR_SEL_P4_SQUELCH;
            `UPTR_OFF_P4_LINK: decode = uptr_pkg::UPTR_SEL_P4_LINK;
            default: decode = uptr_pkg::UPTR_SEL_NONE;
        endcase
    endfunction

    // Status byte: state high, reserved bit zero, sub-state low
    function automatic logic [7:0] link_byte
    (
        input uptr_pkg::uptr_link_t l
    );
        link_byte = {l.state, `UPTR_RSVD_ZERO, l.sub_state};
    endfunction

    // ======================================================
    // Link status synchronisers
    // Two stages each; status is a slow level so per-bit sync is fine
    logic [13:0] sync1_q;
    logic [13:0] sync2_q;
    logic [13:0] sync1_d;
    logic [13:0] sync2_d;
    uptr_pkg::uptr_link_t p2_s;
    uptr_pkg::uptr_link_t p3_s;
    uptr_pkg::uptr_link_t p4_s;

    always_comb
    begin
        sync1_d = sync1_q;
        sync2_d = sync2_q;
        if (CE)
        begin
            sync1_d = {P2_LINK, P3_LINK};
            sync2_d = sync1_q;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1_q <= `UPTR_SYNC_RESET;
            sync2_q <= `UPTR_SYNC_RESET;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    logic [6:0] p4_sync1_q;
    logic [6:0] p4_sync2_q;
    logic [6:0] p4_sync1_d;
    logic [6:0] p4_sync2_d;

    always_comb
    begin
        p4_sync1_d = p4_sync1_q;
        p4_sync2_d = p4_sync2_q;
        if (CE)
        begin
            p4_sync1_d = P4_LINK;
            p4_sync2_d = p4_sync1_q;
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            p4_sync1_q <= `UPTR_LINK_RESET;
            p4_sync2_q <= `UPTR_LINK_RESET;
        end
        else
        begin
            p4_sync1_q <= p4_sync1_d;
            p4_sync2_q <= p4_sync2_d;
        end
    end

    assign p2_s = sync2_q[13:7];
    assign p3_s = sync2_q[6:0];
    assign p4_s = p4_sync2_q;

    // ======================================================
    // Trim registers
    // Codes are kept verbatim; unclear codes are the analog side's concern
    logic [2:0] p3_drive_q;
    logic [2:0] p3_drive_d;
    logic [4:0] p4_upper_q;
    logic [4:0] p4_upper_d;
    logic [4:0] p3_upper_q;
    logic [4:0] p3_upper_d;
    logic [2:0] p4_drive_q;
    logic [2:0] p4_drive_d;
    logic [2:0] p3_sq_q;
    logic [2:0] p3_sq_d;
    logic [2:0] p4_sq_q;
    logic [2:0] p4_sq_d;
    uptr_pkg::uptr_sel_t wsel;

    always_comb
    begin
        wsel = decode(ADDR);
        p3_drive_d = p3_drive_q;
        p3_upper_d = p3_upper_q;
        p4_drive_d = p4_drive_q;
        p4_upper_d = p4_upper_q;
        p3_sq_d = p3_sq_q;
        p4_sq_d = p4_sq_q;
        if (CE && WR)
        begin
            case (wsel)
                uptr_pkg::UPTR_SEL_P3_DRIVE:
                begin
                    p3_drive_d = WDATA[`UPTR_TRIM_HI:`UPTR_TRIM_LO];
                    p3_upper_d = WDATA[`UPTR_UPPER_HI:`UPTR_UPPER_LO];
                end
                uptr_pkg::UPTR_SEL_P4_DRIVE:
                begin
                    p4_drive_d = WDATA[`UPTR_TRIM_HI:`UPTR_TRIM_LO];
                    p4_upper_d = WDATA[`UPTR_UPPER_HI:`UPTR_UPPER_LO];
                end
                uptr_pkg::UPTR_SEL_P3_SQUELCH:
                    p3_sq_d = WDATA[`UPTR_TRIM_HI:`UPTR_TRIM_LO];
                uptr_pkg::UPTR_SEL_P4_SQUELCH:
                    p4_sq_d = WDATA[`UPTR_TRIM_HI:`UPTR_TRIM_LO];
                default:
                    p3_sq_d = p3_sq_q;
            endcase
        end
    end

    // Reset to nominal current and the 100 mV trip point
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            p3_drive_q <= `UPTR_TRIM_NOMINAL;
            p3_upper_q <= `UPTR_UPPER_RESET;
            p4_drive_q <= `UPTR_TRIM_NOMINAL;
            p4_upper_q <= `UPTR_UPPER_RESET;
            p3_sq_q <= `UPTR_TRIM_NOMINAL;
            p4_sq_q <= `UPTR_TRIM_NOMINAL;
        end
        else
        begin
            p3_drive_q <= p3_drive_d;
            p3_upper_q <= p3_upper_d;
            p4_drive_q <= p4_drive_d;
            p4_upper_q <= p4_upper_d;
            p3_sq_q <= p3_sq_d;
            p4_sq_q <= p4_sq_d;
        end
    end

    // ======================================================
    // Trim outputs, registered so they never glitch into the PHY
    uptr_pkg::uptr_trim_t p3_trim_q;
    uptr_pkg::uptr_trim_t p4_trim_q;
    uptr_pkg::uptr_trim_t p3_trim_d;
    uptr_pkg::uptr_trim_t p4_trim_d;

    always_comb
    begin
        p3_trim_d = p3_trim_q;
        p4_trim_d = p4_trim_q;
        if (CE)
        begin
            p3_trim_d = {p3_drive_q, p3_sq_q};
            p4_trim_d = {p4_drive_q, p4_sq_q};
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            p3_trim_q <= {`UPTR_TRIM_NOMINAL, `UPTR_TRIM_NOMINAL};
            p4_trim_q <= {`UPTR_TRIM_NOMINAL, `UPTR_TRIM_NOMINAL};
        end
        else
        begin
            p3_trim_q <= p3_trim_d;
            p4_trim_q <= p4_trim_d;
        end
    end

    assign P3_TRIM = p3_trim_q;
    assign P4_TRIM = p4_trim_q;

    // ======================================================
    // Read path: data stands from the cycle after the strobe until the next CE cycle clears it
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    uptr_pkg::uptr_sel_t rsel;

    always_comb
    begin
        rsel = decode(ADDR);
        rdata_d = rdata_q;
        if (CE)
        begin
            rdata_d = `UPTR_BYTE_ZERO;
            if (RD)
            begin
                case (rsel)
                    uptr_pkg::UPTR_SEL_P2_LINK:
                        rdata_d = link_byte(p2_s);
                    uptr_pkg::UPTR_SEL_P3_LINK:
                        rdata_d = link_byte(p3_s);
                    uptr_pkg::UPTR_SEL_P4_LINK:
                        rdata_d = link_byte(p4_s);
                    uptr_pkg::UPTR_SEL_P3_DRIVE:
                        rdata_d = {p3_upper_q, p3_drive_q};
                    uptr_pkg::UPTR_SEL_P4_DRIVE:
                        rdata_d = {p4_upper_q, p4_drive_q};
                    uptr_pkg::UPTR_SEL_P3_SQUELCH:
                        rdata_d = {`UPTR_UPPER_RESET, p3_sq_q};
                    uptr_pkg::UPTR_SEL_P4_SQUELCH:
                        rdata_d = {`UPTR_UPPER_RESET, p4_sq_q};
                    default:
                        rdata_d = `UPTR_BYTE_ZERO;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            rdata_q <= `UPTR_BYTE_ZERO;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign RDATA = rdata_q;

endmodule // uptr_port_tuning_regs

// *** tb/uptr_port_tuning_regs_chk.sv ***
/*
 * Concurrent checks on the port tuning bank ports.
 * Assumes the bank top module, bound below by name.
 */
`timescale 1ns/1ps

module uptr_port_tuning_regs_chk
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire uptr_pkg::uptr_link_t P2_LINK,
    input wire uptr_pkg::uptr_link_t P3_LINK,
    input wire uptr_pkg::uptr_link_t P4_LINK,
    input wire uptr_pkg::uptr_trim_t P3_TRIM,
    input wire uptr_pkg::uptr_trim_t P4_TRIM
);
    // ======================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_idle;
        CE && !RD |=> RDATA == 8'h00;
    endproperty
    a_idle: assert property (p_idle) else $error("rdata not idle");

    property p_link_rsvd;
        CE && RD && ADDR inside {16'h69C0, 16'h6DC0, 16'h71C0}
            |=> RDATA[3] == 1'b0;
    endproperty
    a_link_rsvd: assert property (p_link_rsvd) else $error("bit3");

    property p_sq_upper;
        CE && RD && ADDR inside {16'h6CCC, 16'h70CC} |=> RDATA[7:3] == 5'h00;
    endproperty
    a_sq_upper: assert property (p_sq_upper) else $error("sq upper");

    property p_p3_drive;
        CE && WR && ADDR == 16'h6CCA ##1 CE
            |=> P3_TRIM.drive == $past(WDATA[2:0], 2);
    endproperty
    a_p3_drive: assert property (p_p3_drive) else $error("p3 drive");

    property p_p4_sq;
        CE && WR && ADDR == 16'h70CC ##1 CE
            |=> P4_TRIM.squelch == $past(WDATA[2:0], 2);
    endproperty
    a_p4_sq: assert property (p_p4_sq) else $error("p4 squelch");

    property p_drive_rb;
        CE && WR && ADDR == 16'h70CA ##1 !(CE && WR)
            ##1 CE && RD && ADDR == 16'h70CA |=> RDATA == $past(WDATA, 3);
    endproperty
    a_drive_rb: assert property (p_drive_rb) else $error("p4 drive");

    property p_hold;
        CE && !WR |-> ##2 $stable(P3_TRIM) && $stable(P4_TRIM);
    endproperty
    a_hold: assert property (p_hold) else $error("trim moved");

    // Link inputs held long enough to cross both sync stages
    property p_p2_link;
        (CE && $stable(P2_LINK))[*4] ##0 RD && ADDR == 16'h69C0
            |=> RDATA == {$past(P2_LINK.state), 1'b0,
            $past(P2_LINK.sub_state)};
    endproperty
    a_p2_link: assert property (p_p2_link) else $error("p2 link");

    property p_p3_link;
        (CE && $stable(P3_LINK))[*4] ##0 RD && ADDR == 16'h6DC0
            |=> RDATA == {$past(P3_LINK.state), 1'b0,
            $past(P3_LINK.sub_state)};
    endproperty
    a_p3_link: assert property (p_p3_link) else $error("p3 link");
endmodule // uptr_port_tuning_regs_chk

bind uptr_port_tuning_regs uptr_port_tuning_regs_chk u_chk
(
    .CLK(CLK), .RESETN(RESETN), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .P2_LINK(P2_LINK),
    .P3_LINK(P3_LINK), .P4_LINK(P4_LINK), .P3_TRIM(P3_TRIM),
    .P4_TRIM(P4_TRIM)
);

// *** tb/tb_usb_port_phy_tuning_regs.sv ***
/*
 * Self-checking bench for the port tuning bank.
 * Assumes the design package and bank on the compile list.
 */
`timescale 1ns/1ps

module tb_usb_port_phy_tuning_regs;
    // ======================================================
    // Map and writable masks
    localparam logic [15:0] A [7] = '{16'h69C0, 16'h6CCA, 16'h6CCC,
        16'h6DC0, 16'h70CA, 16'h70CC, 16'h71C0};
    localparam logic [7:0] M [7] = '{8'h00, 8'hFF, 8'h07, 8'h00, 8'hFF,
        8'h07, 8'h00};
    logic clk, resetn, ce, wr, rd;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, d;
    uptr_pkg::uptr_link_t p2, p3, p4;
    uptr_pkg::uptr_trim_t t3, t4;
    logic [7:0] m [7];
    int n_mismatch, n_compared, cyc, i;

    uptr_port_tuning_regs uut
    (
        .CLK(clk), .RESETN(resetn), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .P2_LINK(p2), .P3_LINK(p3),
        .P4_LINK(p4), .P3_TRIM(t3), .P4_TRIM(t4)
    );

    // ======================================================
    // Helpers
    task chk(input string s, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
            n_mismatch++;
        end
    endtask

    function logic [7:0] ev(input int k);
        case (k)
            0: return {p2.state, 1'b0, p2.sub_state};
            3: return {p3.state, 1'b0, p3.sub_state};
            6: return {p4.state, 1'b0, p4.sub_state};
            default: return m[k];
        endcase
    endfunction

    // Trims lag the register by an edge, so only checked on reads
    task op(input bit w, input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
        if (!w)
        begin
            chk("rdata", v, rdata);
            chk("trim3", {2'b00, m[1][2:0], m[2][2:0]}, {2'b00, t3});
            chk("trim4", {2'b00, m[4][2:0], m[5][2:0]}, {2'b00, t4});
        end
    endtask

    task wput(input int k, input logic [7:0] v);
        op(1'b1, A[k], v);
        m[k] = (m[k] & ~M[k]) | (v & M[k]);
    endtask

    task finish_test;
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ======================================================
    // Clock, timeout and sequence
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            finish_test;
        end
    end

    initial
    begin
        {resetn, ce, wr, rd, addr, wdata, p2, p3, p4} = '0;
        n_mismatch = 0;
        n_compared = 0;
        cyc = 0;
        ce = 1'b1;
        foreach (m[k]) m[k] = 8'h00;
        void'($urandom(84));
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (i = 0; i < 7; i++) op(1'b0, A[i], ev(i));
        for (i = 0; i < 8; i++)
        begin
            wput(2, {5'h1F, i[2:0]});
            wput(5, {5'h15, i[2:0]});
            op(1'b0, A[2], ev(2));
            op(1'b0, A[5], ev(5));
        end
        wput(4, 8'hF5);
        op(1'b0, A[4], ev(4));
        p2 <= 7'($urandom);
        p3 <= 7'($urandom);
        p4 <= 7'($urandom);
        repeat (4) @(posedge clk);
        op(1'b1, A[3], 8'hFF);
        op(1'b0, A[0], ev(0));
        op(1'b0, A[3], ev(3));
        op(1'b0, A[6], ev(6));
        op(1'b1, 16'h6CCB, 8'hFF);
        op(1'b0, 16'h6CCB, 8'h00);
        ce <= 1'b0;
        op(1'b1, A[1], 8'h07);
        ce <= 1'b1;
        op(1'b0, A[1], ev(1));
        repeat (300)
        begin
            i = $urandom % 7;
            d = 8'($urandom);
            if ($urandom % 2)
                wput(i, d);
            else
                op(1'b0, A[i], ev(i));
        end
        // Mid-run reset: trims back to nominal, sync refilled first
        resetn <= 1'b0;
        foreach (m[k]) m[k] = 8'h00;
        @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        for (i = 0; i < 7; i++) op(1'b0, A[i], ev(i));
        finish_test;
    end
endmodule // tb_usb_port_phy_tuning_regs
